// >>> verilog/port_c_pkg.sv
// package: register map, field positions and peripheral bundles for the port c block
package port_c_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [3:0] pin_value_addr  = 4'h0;
    localparam logic [3:0] latch_addr      = 4'h4;
    localparam logic [3:0] direction_addr  = 4'h8;
    localparam logic [3:0] periph_ctrl_addr = 4'hC;

    // ****************************************
    // reset values and widths
    // ****************************************
    localparam int         port_width      = 8;
    localparam logic [7:0] direction_reset = 8'hFF;
    localparam logic [7:0] latch_reset     = 8'h00;
    localparam logic [7:0] ctrl_reset      = 8'h00;

    // ****************************************
    // pin positions
    // ****************************************
    localparam int pin_osc_out   = 0;
    localparam int pin_osc_in    = 1;
    localparam int pin_compare1  = 2;
    localparam int pin_spi_clock = 3;

    // ****************************************
    // peripheral control register fields
    // ****************************************
    localparam int ctrl_osc_en_bit     = 0;
    localparam int ctrl_cmp1_en_bit    = 1;
    localparam int ctrl_cmp2_en_bit    = 2;
    localparam int ctrl_epwm_en_bit    = 3;
    localparam int ctrl_epwm_tri_bit   = 4;
    localparam int ctrl_spi_master_bit = 5;

    // drive requests from the on-chip peripherals
    typedef struct packed {
        logic compare1_out;
        logic compare2_out;
        logic epwm_a_out;
        logic epwm_shutdown;
        logic spi_clock_out;
    } periph_drive_s;

    // input taps handed back to the peripherals
    typedef struct packed {
        logic counter_clock;
        logic capture1;
        logic capture2;
        logic spi_clock;
    } periph_tap_s;

endpackage

// >>> verilog/pin_mux.sv
// per-pin output/enable/input-gating mux for one port pin
`timescale 1ns/1ps
module pin_mux (
    input  wire logic dir_bit_i,
    input  wire logic latch_bit_i,
    input  wire logic analog_i,
    input  wire logic periph_own_i,
    input  wire logic periph_val_i,
    input  wire logic periph_tri_i,
    input  wire logic pad_in_i,
    output logic      pad_out_o,
    output logic      pad_oe_o,
    output logic      dig_in_o
);
    // analog use beats everything; peripheral beats latch only while dir bit is 0
    always_comb begin
        pad_out_o = latch_bit_i;
        pad_oe_o  = ~dir_bit_i;
        if (analog_i) begin
            pad_oe_o  = 1'b0;
            pad_out_o = 1'b0;
        end else if (periph_own_i && !dir_bit_i) begin
            pad_out_o = periph_val_i;
            pad_oe_o  = ~periph_tri_i;
        end
        dig_in_o = analog_i ? 1'b0 : pad_in_i;
    end
endmodule

// >>> verilog/port_c_io.sv
// top of the 8-bit bidirectional port with peripheral overrides and wishbone registers
// Summary of operation
// - eight pins; direction bit 1 releases the driver so the pin is an input
// - direction bit 0 drives the pin from its latch bit
// - latch has its own address; reads return latch, not pin levels
// - reset leaves every pin a digital input
// - direction register reads back as written despite peripheral overrides
// - only the spi master forces pin direction; compare and pwm outputs drive only while the software bit is 0
// - pin-select bit at 1 routes compare unit two to pin 1
// - timer oscillator takes pins 0 and 1 and disables their digital I/O
// - pin 0 as input feeds the shared counter clock
// - compare two output beats latch on pin 1; input feeds its capture
// - compare one output beats latch on pin 2; input feeds its capture
// - enhanced pwm channel a beats latch on pin 2, may tri-state on shutdown
// - spi clock output beats latch on pin 3; input feeds spi clock
`timescale 1ns/1ps
module port_c_io
    import port_c_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // wishbone classic slave
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [3:0]    adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic      [31:0]   dat_o,
    output logic               ack_o,
    output logic               err_o,
    // configuration fuse
    input  wire logic          compare2_pin_select_fuse_i,
    // peripherals
    input  wire periph_drive_s drive_i,
    output periph_tap_s        tap_o,
    // pads
    input  wire logic [7:0]    pad_in_i,
    output logic      [7:0]    pad_out_o,
    output logic      [7:0]    pad_oe_o
);

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] port_direction_reg;
    logic [7:0] port_output_latch;
    logic [7:0] periph_ctrl;
    logic [7:0] dig_in;
    logic [7:0] port_pin_value_reg;
    logic [7:0] periph_own;
    logic [7:0] periph_val;
    logic [7:0] periph_tri;
    logic [7:0] analog;
    logic [7:0] eff_dir;
    logic       cmp2_routed;
    logic       req;
    logic       hit;
    logic       wr;
    logic [7:0] next_rdata;
    logic [7:0] owned_prev;

    function automatic logic known_addr(input logic [3:0] a);
        return (a == pin_value_addr) || (a == latch_addr) ||
               (a == direction_addr) || (a == periph_ctrl_addr);
    endfunction

    // ****************************************
    // wishbone slave: one wait state, ack one cycle
    // ****************************************
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign hit = req && known_addr(adr_i);
    // write lands on the edge at which the master samples ack, not the taking edge
    assign wr  = cyc_i && stb_i && ack_o && we_i && sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= hit;
            err_o <= req && !known_addr(adr_i);
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (adr_i == pin_value_addr) begin
            next_rdata = port_pin_value_reg;
        end else if (adr_i == latch_addr) begin
            next_rdata = port_output_latch;
        end else if (adr_i == direction_addr) begin
            next_rdata = port_direction_reg;
        end else if (adr_i == periph_ctrl_addr) begin
            next_rdata = periph_ctrl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (hit && !we_i) begin
            dat_o <= {24'h00_0000, next_rdata};
        end
    end

    // write to latch or pin address lands in the latch; held even under overrides
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_output_latch <= latch_reset;
        end else if (wr && (adr_i == latch_addr || adr_i == pin_value_addr)) begin
            port_output_latch <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_direction_reg <= direction_reset;
        end else if (wr && adr_i == direction_addr) begin
            port_direction_reg <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_ctrl <= ctrl_reset;
        end else if (wr && adr_i == periph_ctrl_addr) begin
            periph_ctrl <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_pin_value_reg <= 8'h00;
        end else begin
            port_pin_value_reg <= dig_in;
        end
    end

    // ****************************************
    // peripheral override map
    // ****************************************
    assign cmp2_routed = compare2_pin_select_fuse_i && periph_ctrl[ctrl_cmp2_en_bit];

    always_comb begin
        periph_own = 8'h00;
        periph_val = 8'h00;
        periph_tri = 8'h00;
        analog     = 8'h00;
        eff_dir    = port_direction_reg;
        if (periph_ctrl[ctrl_osc_en_bit]) begin
            analog[pin_osc_out] = 1'b1;
            analog[pin_osc_in]  = 1'b1;
        end
        if (cmp2_routed) begin
            periph_own[pin_osc_in] = 1'b1;
            periph_val[pin_osc_in] = drive_i.compare2_out;
        end
        // enhanced channel a wins over plain compare one when both enabled
        if (periph_ctrl[ctrl_epwm_en_bit]) begin
            periph_own[pin_compare1] = 1'b1;
            periph_val[pin_compare1] = drive_i.epwm_a_out;
            periph_tri[pin_compare1] = periph_ctrl[ctrl_epwm_tri_bit] && drive_i.epwm_shutdown;
        end else if (periph_ctrl[ctrl_cmp1_en_bit]) begin
            periph_own[pin_compare1] = 1'b1;
            periph_val[pin_compare1] = drive_i.compare1_out;
        end
        // spi master forces its clock pin to output; otherwise the software bit decides
        if (periph_ctrl[ctrl_spi_master_bit]) begin
            periph_own[pin_spi_clock] = 1'b1;
            periph_val[pin_spi_clock] = drive_i.spi_clock_out;
        end
        eff_dir[pin_spi_clock] = ~periph_ctrl[ctrl_spi_master_bit] &
                                 port_direction_reg[pin_spi_clock];
    end

    // ****************************************
    // pin muxes
    // ****************************************
    for (genvar i = 0; i < port_width; i++) begin : g_pin
        pin_mux u_mux (
            .dir_bit_i    (eff_dir[i]),
            .latch_bit_i  (port_output_latch[i]),
            .analog_i     (analog[i]),
            .periph_own_i (periph_own[i]),
            .periph_val_i (periph_val[i]),
            .periph_tri_i (periph_tri[i]),
            .pad_in_i     (pad_in_i[i]),
            .pad_out_o    (pad_out_o[i]),
            .pad_oe_o     (pad_oe_o[i]),
            .dig_in_o     (dig_in[i])
        );
    end

    // input taps only listen when the pin is an input
    always_comb begin
        tap_o.counter_clock = eff_dir[pin_osc_out] & dig_in[pin_osc_out];
        tap_o.capture2      = cmp2_routed & eff_dir[pin_osc_in] & dig_in[pin_osc_in];
        tap_o.capture1      = eff_dir[pin_compare1] & dig_in[pin_compare1];
        tap_o.spi_clock     = eff_dir[pin_spi_clock] & dig_in[pin_spi_clock];
    end

    // which pins a peripheral held last cycle, for the release check only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            owned_prev <= 8'h00;
        end else begin
            owned_prev <= periph_own;
        end
    end

    // ****************************************
    // assertions: registers and reset
    // ****************************************
    a_reset_inputs: assert property (@(posedge clk_i)
        $past(rst_i) |-> (pad_oe_o == 8'h00))
        else $error("pins not inputs after reset");
    a_reset_values: assert property (@(posedge clk_i)
        $past(rst_i) |-> (port_direction_reg == direction_reset &&
                          port_output_latch == latch_reset))
        else $error("registers not at reset values");
    a_latch_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && adr_i == latch_addr) |=> (port_output_latch == $past(dat_i[7:0])))
        else $error("latch write lost");
    a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && (adr_i == latch_addr || adr_i == pin_value_addr)) |=>
        $stable(port_output_latch))
        else $error("latch changed without a write");
    a_latch_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (hit && !we_i && adr_i == latch_addr) |=> (dat_o[7:0] == $past(port_output_latch)))
        else $error("latch readback wrong");
    a_dir_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (hit && !we_i && adr_i == direction_addr) |=> (dat_o[7:0] == $past(port_direction_reg)))
        else $error("direction readback wrong");
    a_dir_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && adr_i == direction_addr) |=> $stable(port_direction_reg))
        else $error("direction changed without a write");

    // ****************************************
    // assertions: bus
    // ****************************************
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_err_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> !err_o)
        else $error("error longer than one cycle");
    a_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ack_o && err_o))
        else $error("ack and error together");
    a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> (dat_o[31:8] == 24'h00_0000))
        else $error("upper read lanes not zero");
    // a refused access must leave the latch, direction and control registers as they were
    a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> ($stable(port_output_latch) && $stable(port_direction_reg) &&
                   $stable(periph_ctrl)))
        else $error("refused access changed a register");

    // ****************************************
    // assertions: pin drive
    // ****************************************
    a_input_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
        (eff_dir == 8'hFF) |-> (pad_oe_o == 8'h00))
        else $error("input pins driven");
    a_upper_inputs: assert property (@(posedge clk_i) disable iff (rst_i)
        (pad_oe_o[7:4] & port_direction_reg[7:4]) == 4'h0)
        else $error("upper input pin driven");
    a_latch_drives: assert property (@(posedge clk_i) disable iff (rst_i)
        (!eff_dir[5] && !analog[5]) |-> (pad_oe_o[5] && pad_out_o[5] == port_output_latch[5]))
        else $error("latch not on pin");
    a_upper_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        ((pad_out_o[7:4] ^ port_output_latch[7:4]) & ~port_direction_reg[7:4]) == 4'h0)
        else $error("upper output pin not from latch");
    a_no_override: assert property (@(posedge clk_i) disable iff (rst_i)
        (periph_ctrl == ctrl_reset) |-> (pad_oe_o == ~port_direction_reg &&
        ((pad_out_o ^ port_output_latch) & pad_oe_o) == 8'h00))
        else $error("plain port not driven from latch");
    // a pin let go by its peripheral must show the latch again at once
    a_latch_returns: assert property (@(posedge clk_i) disable iff (rst_i)
        ((owned_prev & ~periph_own & ~eff_dir & ~analog) &
         (pad_out_o ^ port_output_latch)) == 8'h00)
        else $error("latch not back after release");
    a_spi_force: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctrl[ctrl_spi_master_bit] |-> pad_oe_o[3] && pad_out_o[3] == drive_i.spi_clock_out)
        else $error("spi clock not forced");
    a_spi_out_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        (periph_ctrl[ctrl_spi_master_bit] && port_direction_reg[pin_spi_clock]) |->
        pad_oe_o[pin_spi_clock])
        else $error("spi master did not override direction");
    a_osc_isolates: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctrl[ctrl_osc_en_bit] |-> (pad_oe_o[1:0] == 2'b00 && dig_in[1:0] == 2'b00))
        else $error("oscillator pins not isolated");
    a_cmp2_route: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmp2_routed && !port_direction_reg[1] && !analog[1]) |->
        pad_out_o[1] == drive_i.compare2_out)
        else $error("compare two not on pin 1");
    a_fuse_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (!compare2_pin_select_fuse_i && !port_direction_reg[pin_osc_in] &&
         !periph_ctrl[ctrl_osc_en_bit]) |->
        (pad_oe_o[pin_osc_in] && pad_out_o[pin_osc_in] == port_output_latch[pin_osc_in]))
        else $error("pin 1 taken without the select bit");
    a_cmp1_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (periph_ctrl[ctrl_cmp1_en_bit] && !periph_ctrl[ctrl_epwm_en_bit] &&
         !port_direction_reg[pin_compare1]) |->
        (pad_oe_o[pin_compare1] && pad_out_o[pin_compare1] == drive_i.compare1_out))
        else $error("compare one not on pin 2");
    a_epwm_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (periph_ctrl[ctrl_epwm_en_bit] && !port_direction_reg[pin_compare1] &&
         !(periph_ctrl[ctrl_epwm_tri_bit] && drive_i.epwm_shutdown)) |->
        (pad_oe_o[pin_compare1] && pad_out_o[pin_compare1] == drive_i.epwm_a_out))
        else $error("pwm channel a not on pin 2");
    a_epwm_tri: assert property (@(posedge clk_i) disable iff (rst_i)
        (periph_ctrl[ctrl_epwm_en_bit] && periph_ctrl[ctrl_epwm_tri_bit] &&
         drive_i.epwm_shutdown) |-> !pad_oe_o[2])
        else $error("pwm shutdown not tri-stated");

    // ****************************************
    // assertions: input taps
    // ****************************************
    a_counter_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_direction_reg[pin_osc_out] && !periph_ctrl[ctrl_osc_en_bit]) |->
        (tap_o.counter_clock == pad_in_i[pin_osc_out]))
        else $error("counter clock not from pin 0");
    a_osc_no_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_ctrl[ctrl_osc_en_bit] |-> (!tap_o.counter_clock && !tap_o.capture2))
        else $error("oscillator pin leaks into a tap");
    a_cap2_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        (compare2_pin_select_fuse_i && periph_ctrl[ctrl_cmp2_en_bit] &&
         port_direction_reg[pin_osc_in] && !periph_ctrl[ctrl_osc_en_bit]) |->
        (tap_o.capture2 == pad_in_i[pin_osc_in]))
        else $error("capture two not from pin 1");
    a_cap1_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        port_direction_reg[pin_compare1] |-> (tap_o.capture1 == pad_in_i[pin_compare1]))
        else $error("capture one not from pin 2");
    a_spi_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        (port_direction_reg[pin_spi_clock] && !periph_ctrl[ctrl_spi_master_bit]) |->
        (tap_o.spi_clock == pad_in_i[pin_spi_clock]))
        else $error("spi clock input not from pin 3");
    a_pin_sample: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (port_pin_value_reg[7:4] == $past(pad_in_i[7:4])))
        else $error("pin value not sampled");

    c_latch_write: cover property (@(posedge clk_i) wr && adr_i == latch_addr);
    c_osc_on: cover property (@(posedge clk_i) periph_ctrl[ctrl_osc_en_bit]);
    c_epwm_shut: cover property (@(posedge clk_i) periph_tri[2]);
    c_bus_err: cover property (@(posedge clk_i) err_o);
    c_spi_master: cover property (@(posedge clk_i) periph_ctrl[ctrl_spi_master_bit]);

endmodule

// >>> verification/port_c_far_end.sv
// far-side model: external circuit that meets the port pads
`timescale 1ns/1ps
module port_c_far_end (
    input  wire logic       clk_i,
    input  wire logic [7:0] pad_out_i,
    input  wire logic [7:0] pad_oe_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic       ext_en_i,
    output logic      [7:0] pad_in_o
);
    // ****************************************
    // pad level resolution
    // ****************************************
    logic [7:0] last;
    // undriven pins show ext_val_i while ext_en_i is set, else the inverse of the last level, so a stale value never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in_o[i] = pad_oe_i[i] ? pad_out_i[i] : (ext_en_i ? ext_val_i[i] : ~last[i]);
        end
    end
    always_ff @(posedge clk_i) begin
        last <= pad_in_o;
    end
endmodule

// >>> verification/port_c_bidirectional_io_tb.sv
// self-checking testbench for the port c block
`timescale 1ns/1ps
module port_c_bidirectional_io_tb import port_c_pkg::*;;
    // ****************************************
    // signals and instances
    // ****************************************
    logic          clk_i, rst_i, cyc, stb, we, ack, err, fuse, ext_en, e;
    logic [3:0]    adr;
    logic [31:0]   wdat, rdat, r;
    logic [7:0]    pad_in, pad_out, pad_oe, ext_val;
    periph_drive_s drive;
    periph_tap_s   tap;
    int            n_fail, check_count, cycles;
    port_c_io u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
        .compare2_pin_select_fuse_i(fuse), .drive_i(drive), .tap_o(tap),
        .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe));
    port_c_far_end u_far (.clk_i(clk_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_in_o(pad_in));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // a hung bus wait would stall forever, so the cycle ceiling ends the run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ****************************************
    // wishbone classic master
    // ****************************************
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
        r = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic settle();
        @(posedge clk_i);
        @(posedge clk_i);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        wb(1'b0, direction_addr, 8'h00);
        check(r, 32'h000000FF);
        wb(1'b0, latch_addr, 8'h00);
        check(r, 32'h00000000);
        check(pad_oe, 8'h00);
    endtask
    task automatic t_latch();
        wr(latch_addr, 8'hA5);
        ext_val <= 8'h5A;
        settle();
        wb(1'b0, latch_addr, 8'h00);
        check(r, 32'h000000A5);
        wr(direction_addr, 8'h00);
        check({pad_oe, pad_out}, 16'hFFA5);
        wr(direction_addr, 8'hF0);
        check(pad_oe, 8'h0F);
        wb(1'b0, 4'h2, 8'h00);
        check(e, 1'b1);
    endtask
    task automatic t_periph();
        wr(direction_addr, 8'h00);
        wr(latch_addr, 8'h00);
        drive <= 5'b11001;
        wr(periph_ctrl_addr, 8'h06);
        check(pad_out[2:1], 2'b11);
        fuse <= 1'b0;
        settle();
        check(pad_out[1], 1'b0);
        wr(periph_ctrl_addr, 8'h0E);
        check(pad_out[2], 1'b0);
        drive <= 5'b11111;
        wr(periph_ctrl_addr, 8'h1E);
        check(pad_oe[2], 1'b0);
        wr(latch_addr, 8'hFF);
        wb(1'b0, latch_addr, 8'h00);
        check(r, 32'h000000FF);
        wr(periph_ctrl_addr, 8'h00);
        check(pad_out, 8'hFF);
        wr(direction_addr, 8'hFF);
        wr(periph_ctrl_addr, 8'h20);
        check({pad_oe[3], pad_out[3]}, 2'b11);
        wb(1'b0, direction_addr, 8'h00);
        check(r, 32'h000000FF);
        wr(direction_addr, 8'h00);
        wr(periph_ctrl_addr, 8'h01);
        check(pad_oe[1:0], 2'b00);
        wb(1'b0, pin_value_addr, 8'h00);
        check(r[1:0], 2'b00);
    endtask
    task automatic t_taps();
        wr(periph_ctrl_addr, 8'h04);
        wr(direction_addr, 8'hFF);
        fuse <= 1'b1;
        ext_val <= 8'h0D;
        settle();
        check(tap, 4'b1101);
        wb(1'b0, pin_value_addr, 8'h00);
        check(r, 32'h0000000D);
        ext_val <= 8'h02;
        settle();
        check(tap, 4'b0010);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_i, cyc, stb, we, fuse, ext_en} = 6'b100011;
        {adr, wdat, ext_val, cycles, n_fail, check_count} = '0;
        drive = 5'b00000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_latch();
        t_periph();
        t_taps();
        give_verdict();
    end
endmodule
